//--- include/mps_cfg.svh
// Purpose: constants for the monitor power-state sequencer
// Assumes: system clock of 10 MHz
// Notes: times in their own unit, cycle counts derived from them
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_CLK_HZ 10000000
`define MPS_SLEEP_TIMEOUT_MS 1500
`define MPS_SLEEP_CYCLES ((`MPS_CLK_HZ / 1000) * `MPS_SLEEP_TIMEOUT_MS)
`define MPS_IDLE_US 5
`define MPS_IDLE_CYCLES ((`MPS_CLK_HZ / 1000000) * `MPS_IDLE_US)
`define MPS_READY_US 10
`define MPS_READY_CYCLES ((`MPS_CLK_HZ / 1000000) * `MPS_READY_US)
`define MPS_WAKE_US 100
`define MPS_WAKE_CYCLES ((`MPS_CLK_HZ / 1000000) * `MPS_WAKE_US)
`define MPS_MMD_OFF 2'h0
`define MPS_GPIO_RESET 6'h3f
`define MPS_FCH_W 4
`endif

//--- include/mps_pkg.sv
// Purpose: types for the monitor power-state sequencer
// Assumes: included after mps_cfg.svh
// Notes: one-hot state codes
package mps_pkg;
  typedef enum logic [4:0] {
    CORE_SLEEP   = 5'h01,
    CORE_STANDBY = 5'h02,
    CORE_REFRDY  = 5'h04,
    CORE_MEASURE = 5'h08,
    CORE_MONITOR = 5'h10
  } mps_core_type;
  typedef enum logic [2:0] {
    PORT_IDLE   = 3'h1,
    PORT_READY  = 3'h2,
    PORT_ACTIVE = 3'h4
  } mps_port_type;
endpackage

//--- src/mps_link_front.sv
// Purpose: link-clock front end, turns pin activity into toggles
// Assumes: link clock stands still outside frames
// Notes: only toggles leave this domain; sys side syncs them
`timescale 1ns/10ps
module mps_link_front (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic frame_tgl_q,
  output logic bit_tgl_q,
  output logic [7:0] shift_q
);
  logic [2:0] bit_cnt_q; // bit position within the byte
  // bit counter; the clock is still outside frames, so a cut byte
  // leaves it misaligned; later full bytes keep the same offset
  always_ff @(posedge link_clk) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
    end else if (!chip_select_n) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end
  // byte start toggle; flips once per byte so the slow side sees it
  always_ff @(posedge link_clk) begin
    if (rst) begin
      frame_tgl_q <= 1'b0;
    end else if (!chip_select_n && bit_cnt_q == 3'h0) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end
  // byte end toggle, seven bits after the start toggle
  always_ff @(posedge link_clk) begin
    if (rst) begin
      bit_tgl_q <= 1'b0;
    end else if (!chip_select_n && bit_cnt_q == 3'h7) begin
      bit_tgl_q <= ~bit_tgl_q;
    end
  end
  // shifter keeps the last byte seen, for observation only
  always_ff @(posedge link_clk) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (!chip_select_n) begin
      shift_q <= {shift_q[6:0], sdi};
    end
  end
endmodule

//--- src/mps_sequencer.sv
// Purpose: core and serial-port power-state sequencer
// Assumes: straps stable; wake and commands are pin-level events
// Notes: timeout restores config defaults, sleeps the core and idles the port machine
// Notes: link activity crosses as byte toggles plus the synchronised chip select level
// Notes: wake, hold, chip select and data pins pass a two-flop synchroniser first
// Behaviour
// - sleep keeps reference, oscillator, modulator off; wake to standby
// - standby runs oscillator; timer keeps counting
// - standby to ready on keep-on, command, monitor
// - reference-ready plus command goes to measure
// - monitor enable goes monitor; timeout sleeps
// - measure done back; drop to standby without keep-on
// - monitor converts and flags faults on pins 4-6
// - monitor ends on timeout or mode 00
// - hold pin low in monitor suspends timer
// - timeout after 1.5 s without wake
// - timeout restores config defaults
// - timeout sleeps core and idles port machine
// - wake moves port idle to ready, timed
// - port B used only in daisy chain
// - ready returns idle after idle interval
// - traffic puts port machine in active
// - link strap picks two-wire or 4-wire
// - topology strap picks chain or address inputs
// - 4-wire output only pulls low
// - general pins only pulled low
`timescale 1ns/10ps
`include "mps_cfg.svh"
module mps_sequencer #(
  parameter int SLEEP_CYCLES = `MPS_SLEEP_CYCLES,
  parameter int FCH_W = `MPS_FCH_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_type_strap,
  input wire logic chain_topology_strap,
  input wire logic port_a_wake,
  input wire logic port_b_wake,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic [3:0] chip_address_inputs,
  input wire logic conv_cmd,
  input wire logic conv_done,
  input wire logic cfg_we,
  input wire logic cfg_reference_keep_on,
  input wire logic [1:0] cfg_monitor_mode_field,
  input wire logic [FCH_W-1:0] cfg_fault_channel_field,
  input wire logic [5:0] cfg_gpio_ctrl,
  input wire logic [5:0] gpio_i,
  input wire logic [2:0] fault_flags,
  output logic [5:0] gpio_o,
  output logic [5:0] gpio_oe,
  output logic reference_on,
  output logic oscillator_on,
  output logic modulator_on,
  output logic [4:0] core_state,
  output logic [2:0] port_state,
  output logic port_b_enabled,
  output logic two_wire_mode,
  output logic [3:0] chip_address,
  output logic reference_keep_on,
  output logic [1:0] monitor_mode_field,
  output logic [FCH_W-1:0] fault_channel_field,
  output logic timeout_pulse
);
  // interval counts in sys_clk cycles; the idle and wake counters below are 16 bits
  // wide, so a faster clock or longer interval needs wider counters
  localparam int IDLE_CYC = `MPS_IDLE_CYCLES;
  localparam int READY_CYC = `MPS_READY_CYCLES;
  localparam int WAKE_CYC = `MPS_WAKE_CYCLES;

  mps_pkg::mps_core_type core_q; // core power state
  mps_pkg::mps_port_type port_q; // serial port state
  logic [5:0] gpio_ctrl_q; // pin pull-down controls, 1 = released
  logic [31:0] sleep_cnt_q; // inactivity timer
  logic [15:0] idle_cnt_q; // port idle interval
  logic [15:0] wake_cnt_q; // idle-to-ready delay
  logic wake_pend_q; // wake seen, ready delay running
  logic [1:0] wa_sync_q; // port A wake synchroniser
  logic [1:0] wb_sync_q; // port B wake synchroniser
  logic [1:0] hold_sync_q; // timer hold pin synchroniser
  logic [2:0] frm_sync_q; // frame toggle sync plus history
  logic [2:0] bit_sync_q; // bit toggle sync plus history
  logic [1:0] cs_sync_q; // chip select level synchroniser
  logic [1:0] sdi_sync_q; // data in, for readback loop
  logic frame_tgl; // from link domain
  logic bit_tgl; // from link domain
  logic [7:0] link_shift; // last byte, link domain
  logic wake_any; // a wake on an enabled port
  logic traffic; // serial data moved this cycle
  logic hold_timer; // timer suspended
  logic timeout; // inactivity expiry
  logic monitor_en; // monitor mode nonzero

  // link-domain front end; only toggles cross to sys_clk
  // a toggle changes at most once per byte, slower than two sys_clk
  // periods at the link rates in use, so no event is lost
  mps_link_front u_front (
    .link_clk(link_clk),
    .rst(rst),
    .chip_select_n(chip_select_n),
    .sdi(sdi),
    .frame_tgl_q(frame_tgl),
    .bit_tgl_q(bit_tgl),
    .shift_q(link_shift)
  );

  // pin synchronisers; first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wa_sync_q <= 2'h0;
      wb_sync_q <= 2'h0;
      hold_sync_q <= 2'h3;
      cs_sync_q <= 2'h3;
      sdi_sync_q <= 2'h0;
    end else begin
      wa_sync_q <= {wa_sync_q[0], port_a_wake};
      wb_sync_q <= {wb_sync_q[0], port_b_wake};
      hold_sync_q <= {hold_sync_q[0], gpio_i[2]};
      cs_sync_q <= {cs_sync_q[0], chip_select_n};
      sdi_sync_q <= {sdi_sync_q[0], sdi};
    end
  end

  // toggle crossings; stage 2 vs 3 gives the event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frm_sync_q <= 3'h0;
      bit_sync_q <= 3'h0;
    end else begin
      frm_sync_q <= {frm_sync_q[1:0], frame_tgl};
      bit_sync_q <= {bit_sync_q[1:0], bit_tgl};
    end
  end

  // port B wake ignored unless daisy chained
  assign wake_any = wa_sync_q[1] |
    (wb_sync_q[1] & chain_topology_strap);
  assign traffic = (frm_sync_q[2] ^ frm_sync_q[1]) |
    (bit_sync_q[2] ^ bit_sync_q[1]);
  assign monitor_en = (monitor_mode_field != `MPS_MMD_OFF);
  // hold only counts in monitor, with pin pulled low
  assign hold_timer = (core_q == mps_pkg::CORE_MONITOR) &
    ~hold_sync_q[1];
  assign timeout = ~hold_timer &&
    (sleep_cnt_q >= 32'(SLEEP_CYCLES));

  // inactivity timer; any wake or traffic restarts it
  // the count freezes in sleep: nothing is left to switch off there
  // hold beats restart so a held monitor never sees a stale expiry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_cnt_q <= 32'h0;
    end else if (hold_timer) begin
      sleep_cnt_q <= sleep_cnt_q;
    end else if (wake_any || traffic || timeout) begin
      sleep_cnt_q <= 32'h0;
    end else if (core_q != mps_pkg::CORE_SLEEP) begin
      sleep_cnt_q <= sleep_cnt_q + 32'h1;
    end
  end

  // configuration fields; timeout beats a host write
  always_ff @(posedge sys_clk) begin
    if (rst || timeout) begin
      gpio_ctrl_q <= `MPS_GPIO_RESET;
      reference_keep_on <= 1'b0;
      monitor_mode_field <= `MPS_MMD_OFF;
      fault_channel_field <= '0;
    end else if (cfg_we) begin
      gpio_ctrl_q <= cfg_gpio_ctrl;
      reference_keep_on <= cfg_reference_keep_on;
      monitor_mode_field <= cfg_monitor_mode_field;
      fault_channel_field <= cfg_fault_channel_field;
    end
  end

  // core state machine
  // command wins over monitor entry in reference-ready; the
  // drop to standby only happens when nothing asks for the reference
  always_ff @(posedge sys_clk) begin
    if (rst || timeout) begin
      core_q <= mps_pkg::CORE_SLEEP;
    end else begin
      case (core_q)
        mps_pkg::CORE_SLEEP: begin
          if (wake_any) begin
            core_q <= mps_pkg::CORE_STANDBY;
          end
        end
        mps_pkg::CORE_STANDBY: begin
          if (reference_keep_on || conv_cmd || monitor_en) begin
            core_q <= mps_pkg::CORE_REFRDY;
          end
        end
        mps_pkg::CORE_REFRDY: begin
          if (conv_cmd) begin
            core_q <= mps_pkg::CORE_MEASURE;
          end else if (monitor_en) begin
            core_q <= mps_pkg::CORE_MONITOR;
          end else if (!reference_keep_on) begin
            core_q <= mps_pkg::CORE_STANDBY;
          end
        end
        mps_pkg::CORE_MEASURE: begin
          if (conv_done) begin
            core_q <= mps_pkg::CORE_REFRDY;
          end
        end
        mps_pkg::CORE_MONITOR: begin
          if (!monitor_en) begin
            core_q <= mps_pkg::CORE_REFRDY;
          end
        end
        default: begin
          core_q <= mps_pkg::CORE_SLEEP;
        end
      endcase
    end
  end

  // wake delay: short from standby, long from sleep
  // the delay is chosen by the core state at the moment of the wake
  always_ff @(posedge sys_clk) begin
    if (rst || timeout) begin
      wake_pend_q <= 1'b0;
      wake_cnt_q <= 16'h0;
    end else if (port_q == mps_pkg::PORT_IDLE && wake_any &&
                 !wake_pend_q) begin
      wake_pend_q <= 1'b1;
      wake_cnt_q <= (core_q == mps_pkg::CORE_SLEEP) ?
        16'(WAKE_CYC) : 16'(READY_CYC);
    end else if (wake_pend_q) begin
      if (wake_cnt_q <= 16'h1) begin
        wake_pend_q <= 1'b0;
      end
      wake_cnt_q <= wake_cnt_q - 16'h1;
    end
  end

  // idle interval counter, restarted by activity
  always_ff @(posedge sys_clk) begin
    if (rst || wake_any || traffic || port_q != mps_pkg::PORT_READY) begin
      idle_cnt_q <= 16'h0;
    end else if (idle_cnt_q < 16'(IDLE_CYC)) begin
      idle_cnt_q <= idle_cnt_q + 16'h1;
    end
  end

  // port state machine
  // a low chip select counts as activity even before a byte arrives
  always_ff @(posedge sys_clk) begin
    if (rst || timeout) begin
      port_q <= mps_pkg::PORT_IDLE;
    end else begin
      case (port_q)
        mps_pkg::PORT_IDLE: begin
          if (wake_pend_q && wake_cnt_q <= 16'h1) begin
            port_q <= mps_pkg::PORT_READY;
          end
        end
        mps_pkg::PORT_READY: begin
          if (traffic || !cs_sync_q[1]) begin
            port_q <= mps_pkg::PORT_ACTIVE;
          end else if (idle_cnt_q >= 16'(IDLE_CYC)) begin
            port_q <= mps_pkg::PORT_IDLE;
          end
        end
        mps_pkg::PORT_ACTIVE: begin
          if (!traffic && cs_sync_q[1]) begin
            port_q <= mps_pkg::PORT_READY;
          end
        end
        default: begin
          port_q <= mps_pkg::PORT_IDLE;
        end
      endcase
    end
  end

  // open-drain data out: echoes last sampled bit, low only
  // the pin is never driven high; the board pull-up makes the 1s
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~link_type_strap & ~cs_sync_q[1] &
        ~sdi_sync_q[1];
    end
  end
  assign sdo_o = 1'b0;

  // general pins: pull low only; monitor faults on pins 4-6
  // a fault pull is only shown in monitor, so stale flags from a
  // finished measurement never reach the pins
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_gpio
      logic pull_low;
      if (g >= 3) begin : g_fault
        assign pull_low = ~gpio_ctrl_q[g] |
          ((core_q == mps_pkg::CORE_MONITOR) & fault_flags[g-3]);
      end else begin : g_plain
        assign pull_low = ~gpio_ctrl_q[g];
      end
      assign gpio_o[g] = 1'b0;
      assign gpio_oe[g] = pull_low;
    end
  endgenerate

  // power enables per core state
  // decoded straight from the one-hot state, no extra flops needed
  assign oscillator_on = (core_q != mps_pkg::CORE_SLEEP);
  assign reference_on = (core_q == mps_pkg::CORE_REFRDY) |
    (core_q == mps_pkg::CORE_MEASURE) |
    (core_q == mps_pkg::CORE_MONITOR);
  assign modulator_on = (core_q == mps_pkg::CORE_MEASURE) |
    (core_q == mps_pkg::CORE_MONITOR);

  // strap decodes; address inputs trusted only in parallel mode
  assign two_wire_mode = link_type_strap;
  assign port_b_enabled = chain_topology_strap;
  assign chip_address = chain_topology_strap ? 4'h0 :
    chip_address_inputs;
  assign core_state = core_q;
  assign port_state = port_q;
  assign timeout_pulse = timeout;
endmodule

//--- verification/mps_seq_monitor.sv
// Purpose: temporal checks on the sequencer ports
// Assumes: one clock domain, sync active-high reset
// Notes: bound into every sequencer instance
`timescale 1ns/10ps
module mps_seq_monitor #(
  parameter int FCH_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic port_a_wake,
  input wire logic conv_cmd,
  input wire logic conv_done,
  input wire logic [5:0] gpio_i,
  input wire logic sdo_o,
  input wire logic [5:0] gpio_o,
  input wire logic reference_on,
  input wire logic oscillator_on,
  input wire logic modulator_on,
  input wire logic [4:0] core_state,
  input wire logic [2:0] port_state,
  input wire logic reference_keep_on,
  input wire logic [1:0] monitor_mode_field,
  input wire logic [FCH_W-1:0] fault_channel_field,
  input wire logic timeout_pulse
);
  // short names for the core states
  localparam logic [4:0] SLP = mps_pkg::CORE_SLEEP;
  localparam logic [4:0] STB = mps_pkg::CORE_STANDBY;
  localparam logic [4:0] RDY = mps_pkg::CORE_REFRDY;
  localparam logic [4:0] MEA = mps_pkg::CORE_MEASURE;
  localparam logic [4:0] MON = mps_pkg::CORE_MONITOR;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sleep_power_a: assert property (core_state == SLP
    |-> !(reference_on | oscillator_on | modulator_on)) else $error("on");
  wake_standby_a: assert property (core_state == SLP && port_a_wake
    ##1 port_a_wake |-> ##[1:4] core_state == STB) else $error("wake");
  standby_cmd_a: assert property (core_state == STB && conv_cmd
    |=> core_state == RDY) else $error("standby exit");
  refrdy_cmd_a: assert property (core_state == RDY && conv_cmd
    |=> core_state == MEA) else $error("no measure");
  // monitor wins only when no command competes
  monitor_entry_a: assert property (core_state == RDY && !conv_cmd
    && monitor_mode_field != 2'h0 |=> core_state == MON) else $error("mon");
  measure_done_a: assert property (core_state == MEA && conv_done
    |=> core_state == RDY) else $error("measure end");
  refrdy_drop_a: assert property (core_state == RDY && !conv_cmd
    && !reference_keep_on && monitor_mode_field == 2'h0
    |=> core_state == STB) else $error("no drop");
  monitor_exit_a: assert property (core_state == MON
    && monitor_mode_field == 2'h0 |-> ##[0:1] core_state != MON)
    else $error("monitor kept");
  hold_freeze_a: assert property ((core_state == MON && !gpio_i[2])
    [*3] |-> !timeout_pulse) else $error("timeout while held");
  timeout_reset_a: assert property (timeout_pulse
    |-> ##[0:1] (core_state == SLP && port_state == mps_pkg::PORT_IDLE
    && !reference_keep_on && monitor_mode_field == 2'h0
    && fault_channel_field == '0)) else $error("no defaults");
  open_drain_a: assert property (sdo_o == 1'b0
    && gpio_o == 6'h00) else $error("pin driven high");
  measure_c: cover property (core_state == MEA);
  held_c: cover property (core_state == MON && !gpio_i[2]);
  timeout_c: cover property (timeout_pulse);
endmodule
bind mps_sequencer mps_seq_monitor #(.FCH_W(FCH_W)) u_mon (
  .sys_clk, .rst, .port_a_wake, .conv_cmd, .conv_done, .gpio_i,
  .sdo_o, .gpio_o, .reference_on, .oscillator_on, .modulator_on,
  .core_state, .port_state, .reference_keep_on, .monitor_mode_field,
  .fault_channel_field, .timeout_pulse
);

//--- verification/mps_host_model.sv
// Purpose: host end of the 4-wire link
// Assumes: link clock 48 ns, low outside frames, still there except four deselected clocks at time zero
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/10ps
module mps_host_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic sdi
);
  // idle bus at time zero
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b1;
    // a few deselected clocks so the link side sees reset
    repeat (4) begin
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
  end
  // one byte, msb first, data moves while the clock is low
  task automatic send_frame(input logic [7:0] b);
    chip_select_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    #100 chip_select_n = 1'b1;
    sdi = ~sdi; // no stale level after release
  endtask
endmodule

//--- verification/mps_sequencer_tb_top.sv
// Purpose: directed bench for the power-state sequencer
// Assumes: chain topology, 4-wire link, sleep count cut to 2000
// Notes: each scenario task drives and judges on its own
`timescale 1ns/10ps
module mps_sequencer_tb_top;
  localparam int SLP_CYC = 2000; // short inactivity count
  logic sys_clk = 1'b0, rst = 1'b1, port_a_wake = 1'b0, port_b_wake = 1'b0;
  logic conv_cmd = 1'b0, conv_done = 1'b0, cfg_we = 1'b0;
  logic cfg_reference_keep_on = 1'b0;
  logic [1:0] cfg_monitor_mode_field = 2'h0;
  logic [3:0] cfg_fault_channel_field = 4'h0;
  logic [5:0] cfg_gpio_ctrl = 6'h3f, gpio_i = 6'h3f;
  logic [2:0] fault_flags = 3'h5; // faults on pins 4 and 6
  logic [3:0] chip_address_inputs = 4'h9;
  logic link_clk, chip_select_n, sdi, sdo_o, sdo_oe, timeout_pulse;
  logic [5:0] gpio_o, gpio_oe;
  logic reference_on, oscillator_on, modulator_on, reference_keep_on;
  logic port_b_enabled, two_wire_mode;
  logic [4:0] core_state;
  logic [2:0] port_state;
  logic [3:0] chip_address, fault_channel_field;
  logic [1:0] monitor_mode_field;
  int n_fail = 0, tests_run = 0;
  always #50 sys_clk = ~sys_clk;
  mps_host_model u_host (.link_clk, .chip_select_n, .sdi);
  mps_sequencer #(.SLEEP_CYCLES(SLP_CYC)) dut (
    .sys_clk, .rst, .link_clk, .link_type_strap(1'b0),
    .chain_topology_strap(1'b1), .port_a_wake, .port_b_wake,
    .chip_select_n, .sdi, .sdo_o, .sdo_oe, .chip_address_inputs,
    .conv_cmd, .conv_done, .cfg_we, .cfg_reference_keep_on,
    .cfg_monitor_mode_field, .cfg_fault_channel_field, .cfg_gpio_ctrl,
    .gpio_i, .fault_flags, .gpio_o, .gpio_oe, .reference_on,
    .oscillator_on, .modulator_on, .core_state, .port_state,
    .port_b_enabled, .two_wire_mode, .chip_address, .reference_keep_on,
    .monitor_mode_field, .fault_channel_field, .timeout_pulse);
  // inputs move 5 ns after the edge, checks look there too
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // bounded poll of core (p=0) or port (p=1) state
  task automatic wait_st(input logic p, input logic [4:0] w, input int l);
    int i;
    for (i = 0; i < l && (p ? {2'h0, port_state} : core_state) !== w; i++)
      tick(1);
    if (i == l) begin
      chk("state_wait", 8'hff, {3'h0, w});
      finish_test();
    end
  endtask
  task automatic wake(input logic b);
    port_a_wake = !b;
    port_b_wake = b;
    tick(2);
    {port_a_wake, port_b_wake} = 2'h0;
  endtask
  task automatic cfg(input logic k, input logic [1:0] m, input logic [5:0] g);
    {cfg_reference_keep_on, cfg_monitor_mode_field} = {k, m};
    cfg_fault_channel_field = 4'ha;
    cfg_gpio_ctrl = g;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // wake from sleep is slow, then the idle port powers down
  task automatic s_wake();
    chk("straps", {two_wire_mode, port_b_enabled, chip_address}, 8'h10);
    wake(1'b0);
    wait_st(1'b0, mps_pkg::CORE_STANDBY, 6);
    chk("power", {reference_on, oscillator_on, modulator_on}, 8'h2);
    tick(500);
    chk("port", port_state, mps_pkg::PORT_IDLE);
    wait_st(1'b1, mps_pkg::PORT_READY, 600);
    wait_st(1'b1, mps_pkg::PORT_IDLE, 80);
  endtask
  // back-to-back commands, then finish with keep-on clear
  task automatic s_measure();
    conv_cmd = 1'b1;
    tick(1);
    chk("core", core_state, mps_pkg::CORE_REFRDY);
    tick(1);
    {conv_cmd, conv_done} = 2'h1;
    chk("power", {reference_on, oscillator_on, modulator_on}, 8'h7);
    chk("oe", gpio_oe, 8'h00);
    tick(1);
    conv_done = 1'b0;
    chk("core", core_state, mps_pkg::CORE_REFRDY);
    tick(1);
    chk("core", core_state, mps_pkg::CORE_STANDBY);
  endtask
  // port b wake in chain mode, then one frame of traffic
  task automatic s_frame();
    wake(1'b1);
    wait_st(1'b1, mps_pkg::PORT_READY, 150);
    fork
      u_host.send_frame(8'ha5);
    join_none
    wait_st(1'b1, mps_pkg::PORT_ACTIVE, 12);
    wait_st(1'b1, mps_pkg::PORT_READY, 30);
    chk("sdo_oe", {7'h0, sdo_oe}, 8'h0);
  endtask
  // held monitor must outlive the inactivity count
  task automatic s_monitor();
    cfg(1'b0, 2'h1, 6'h3f);
    wait_st(1'b0, mps_pkg::CORE_MONITOR, 6);
    chk("oe", gpio_oe, 8'h28);
    gpio_i = 6'h3b;
    tick(SLP_CYC + 100);
    chk("core", core_state, mps_pkg::CORE_MONITOR);
    gpio_i = 6'h3f;
    cfg(1'b0, 2'h0, 6'h3f);
    wait_st(1'b0, mps_pkg::CORE_STANDBY, 6);
  endtask
  // a late wake restarts the count; expiry restores defaults
  task automatic s_timeout();
    int n;
    cfg(1'b1, 2'h0, 6'h3e);
    tick(2);
    chk("core", core_state, mps_pkg::CORE_REFRDY);
    chk("oe", gpio_oe, 8'h01);
    wake(1'b0);
    tick(SLP_CYC - 500);
    wake(1'b1);
    for (n = 0; n < SLP_CYC + 20 && timeout_pulse !== 1'b1; n++) tick(1);
    chk("expiry", {7'h0, n >= SLP_CYC - 3 && n <= SLP_CYC + 6}, 8'h1);
    if (timeout_pulse !== 1'b1) finish_test();
    tick(2);
    chk("core", {port_state, core_state}, 8'h21);
    chk("cfg", {1'b0, reference_keep_on, monitor_mode_field,
      fault_channel_field}, 8'h0);
    chk("oe", {2'h0, gpio_oe}, 8'h0);
  endtask
  initial begin
    tick(3);
    rst = 1'b0;
    tick(3);
    s_wake();
    s_measure();
    s_frame();
    s_monitor();
    s_timeout();
    finish_test();
  end
endmodule
